//--- pll_programmable_divider.sv
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Operation
// RL1 - prescalers, 4-bit swallow, 13-bit main counter
// RL2 - select port increments after each data access
// RL3 - controller writes nibbles into selected group
// RL4 - msb write transfers all divisor bits
// RL5 - band bits choose direct or swallow modes
// RL6 - highest band adds divide-by-two front stage
// RL7 - highest band doubles programmed ratio
// RL8 - offset bits give n, n-1, n+1
// RL9 - offset ignored in direct division
// RL10 - swallow modes use 17-bit binary number
// RL11 - direct mode uses bits 4 to 16
// RL12 - direct number kept within 16 to 8191 (not enforced: any value in bits 4 to 16 loads)
// RL13 - direct mode clocks main counter directly
// RL14 - unselected or off inputs pulled down
// RL15 - mode bits written at channel zero
// RL16 - select, data, msb at channels one to three
// RL17 - swallow count picks 16 cycles, rest 15
// RL18 - reference all ones stops loop
// RL19 - reference write updates pending setting
module pll_programmable_divider
	import pll_divider_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic low_band_rf_input,
	input wire logic high_band_rf_input,
	output logic low_band_pulldown,
	output logic high_band_pulldown,
	output logic divided_out,
	output logic loop_off
);

	// ===========================================
	// helpers
	// division number after the offset, swallow modes only
	function automatic logic [DIV_W-1:0] offset_count(input logic [DIV_W-1:0] n, input logic [3:0] mode);
		logic [DIV_W-1:0] r;
		r = n;
		if (mode[OFFSET_PLUS_POS])
			r = DIV_W'(n + 1'b1); // see RL8
		else if (mode[OFFSET_MINUS_POS])
			r = DIV_W'(n - 1'b1); // see RL8
		return r;
	endfunction

	// band decode of the two band bits
	function automatic band_mode_t band_of(input logic [3:0] mode);
		band_mode_t b;
		case ({mode[UPPER_BAND_POS], mode[SWALLOW_BAND_POS]})
			2'b00: b = direct_divide_mode; // see RL5
			2'b01: b = swallow_low_mode;
			2'b10: b = swallow_high_mode;
			default: b = doubled_swallow_mode;
		endcase
		return b;
	endfunction

	// ===========================================
	// register state
	logic [3:0] mode, next_mode;                           // band and offset bits
	logic [SEL_W-1:0] sel, next_sel;                       // group pointer
	logic [NIBBLE_W-1:0] pending [GROUPS], next_pending [GROUPS]; // low 16 bits waiting
	logic [REF_W-1:0] ref_sel, next_ref_sel;               // reference selection
	logic [DIV_W-1:0] active, next_active;                 // divisor in use
	logic commit, next_commit;                             // one-cycle restart request
	logic [DATA_W-1:0] next_prdata;
	logic next_pready, next_pslverr;
	logic low_pd, next_low_pd, high_pd, next_high_pd, off, next_off;

	logic access;     // access phase with answer already up
	logic mapped;     // address hits a register
	band_mode_t band;

	assign access = psel & penable & pready;
	assign band = band_of(mode);

	always_comb begin
		mapped = 1'b1;
		case (paddr)
			MODE_ADDR, SELECT_ADDR, DATA_ADDR, REF_MSB_ADDR, ACTIVE_ADDR, STATUS_ADDR: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// ===========================================
	// apb slave and register file
	// one wait state: pready rises in the second access cycle, which lets
	// prdata come from a flop without a combinational read path
	always_comb begin
		next_mode = mode;
		next_sel = sel;
		next_pending = pending;
		next_ref_sel = ref_sel;
		next_active = active;
		next_commit = 1'b0;
		next_prdata = prdata;
		next_pready = psel & penable & ~pready;
		next_pslverr = 1'b0;
		if (psel & penable & ~pready) begin
			// answer prepared one cycle ahead of the sampling edge
			next_pslverr = ~mapped;
			next_prdata = '0;
			if (!pwrite) begin
				case (paddr)
					MODE_ADDR: next_prdata = DATA_W'(mode);
					SELECT_ADDR: next_prdata = DATA_W'(sel);
					DATA_ADDR: next_prdata = DATA_W'(pending[sel]);
					REF_MSB_ADDR: next_prdata = DATA_W'({active[DIV_W-1], ref_sel});
					ACTIVE_ADDR: next_prdata = DATA_W'(active);
					STATUS_ADDR: next_prdata = DATA_W'({low_pd, off});
					default: next_prdata = '0;
				endcase
			end
		end
		if (access) begin
			// effects land only at the edge that completes the transfer
			case (paddr)
				MODE_ADDR: begin
					if (pwrite)
						next_mode = pwdata[3:0]; // see RL15
				end
				SELECT_ADDR: begin
					if (pwrite)
						next_sel = pwdata[SEL_W-1:0]; // see RL16
				end
				DATA_ADDR: begin
					if (pwrite)
						next_pending[sel] = pwdata[NIBBLE_W-1:0]; // see RL3
					next_sel = SEL_W'(sel + 1'b1); // see RL2
				end
				REF_MSB_ADDR: begin
					if (pwrite) begin
						next_ref_sel = pwdata[REF_W-1:0]; // see RL19
						next_active = {pwdata[MSB_POS], next_pending[3], next_pending[2],
							next_pending[1], next_pending[0]}; // see RL4
						next_commit = 1'b1;
					end
				end
				default: begin
					// read-only or unmapped: no effect
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= MODE_RESET;
			sel <= SEL_RESET;
			for (int i = 0; i < GROUPS; i++)
				pending[i] <= '0;
			ref_sel <= REF_OFF;
			active <= DIV_RESET;
			commit <= 1'b0;
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			mode <= next_mode;
			sel <= next_sel;
			pending <= next_pending;
			ref_sel <= next_ref_sel;
			active <= next_active;
			commit <= next_commit;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ===========================================
	// input select and pulldowns
	// low band for direct and lower swallow mode, high band otherwise
	logic use_low;
	assign use_low = (band == direct_divide_mode) | (band == swallow_low_mode);

	always_comb begin
		next_off = (ref_sel == REF_OFF); // see RL18
		next_low_pd = next_off | ~use_low; // see RL14
		next_high_pd = next_off | use_low; // see RL14
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			off <= 1'b1;
			low_pd <= 1'b1;
			high_pd <= 1'b1;
		end else begin
			off <= next_off;
			low_pd <= next_low_pd;
			high_pd <= next_high_pd;
		end
	end

	assign loop_off = off;
	assign low_band_pulldown = low_pd;
	assign high_band_pulldown = high_pd;

	// ===========================================
	// divider chain
	// the rf inputs are sampled on pclk, so the input rate is bounded by
	// half the bus clock; a real front end would run on the rf edge itself
	logic rf_prev, next_rf_prev;                          // last sampled input level
	logic half, next_half;                                // divide-by-two front stage
	logic [SWALLOW_W-1:0] pre_cnt, next_pre_cnt;          // prescaler phase
	logic [SWALLOW_W-1:0] swallow_left, next_swallow_left; // long cycles remaining
	logic [MAIN_W-1:0] main_left, next_main_left;         // main counter
	logic pulse, next_pulse;
	logic rf_now, rf_edge, counted;
	logic [DIV_W-1:0] n_eff, quot;
	logic [SWALLOW_W-1:0] rem_load;
	logic [MAIN_W-1:0] main_load;

	assign rf_now = use_low ? low_band_rf_input : high_band_rf_input;
	assign rf_edge = rf_now & ~rf_prev;
	// every edge counts, except that the highest band passes every second one
	assign counted = rf_edge & ((band != doubled_swallow_mode) | half); // see RL6

	always_comb begin
		// split n into 15*q + r so that r blocks of 16 and q-r blocks of 15 give n
		n_eff = offset_count(active, mode); // see RL10
		quot = n_eff / SHORT_MOD;
		rem_load = SWALLOW_W'(n_eff - DIV_W'(quot * SHORT_MOD)); // see RL17
		main_load = MAIN_W'(quot); // see RL1
		if (band == direct_divide_mode) begin
			rem_load = '0; // see RL9
			main_load = active[DIV_W-1:NIBBLE_W]; // see RL11
		end
	end

	always_comb begin
		next_rf_prev = rf_now;
		next_half = half;
		next_pre_cnt = pre_cnt;
		next_swallow_left = swallow_left;
		next_main_left = main_left;
		next_pulse = 1'b0;
		if (off || commit) begin
			// stopped or restarted with the newly committed setting
			next_half = 1'b0;
			next_pre_cnt = '0;
			next_swallow_left = rem_load;
			next_main_left = main_load;
		end else begin
			if (rf_edge)
				next_half = ~half;
			if (counted) begin
				if (band == direct_divide_mode) begin
					// prescaler bypassed, main counter sees every edge
					if (main_left <= 1) begin // see RL13
						next_main_left = main_load;
						next_pulse = 1'b1;
					end else begin
						next_main_left = MAIN_W'(main_left - 1'b1);
					end
				end else if (pre_cnt == ((swallow_left != 0) ? LONG_LAST : SHORT_LAST)) begin
					// one prescaler block done: 16 while swallowing, else 15
					next_pre_cnt = '0;
					if (swallow_left != 0)
						next_swallow_left = SWALLOW_W'(swallow_left - 1'b1); // see RL17
					if (main_left <= 1) begin
						next_main_left = main_load;
						next_swallow_left = rem_load;
						next_pulse = 1'b1; // see RL7
					end else begin
						next_main_left = MAIN_W'(main_left - 1'b1);
					end
				end else begin
					next_pre_cnt = SWALLOW_W'(pre_cnt + 1'b1);
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rf_prev <= 1'b0;
			half <= 1'b0;
			pre_cnt <= '0;
			swallow_left <= '0;
			main_left <= '0;
			pulse <= 1'b0;
		end else begin
			rf_prev <= next_rf_prev;
			half <= next_half;
			pre_cnt <= next_pre_cnt;
			swallow_left <= next_swallow_left;
			main_left <= next_main_left;
			pulse <= next_pulse;
		end
	end

	assign divided_out = pulse;

endmodule

`default_nettype wire

//--- pll_divider_pkg.sv
package pll_divider_pkg;
	// ===========================================
	// bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// ===========================================
	// register byte addresses
	localparam logic [7:0] MODE_ADDR = 8'h00;       // band mode and offset bits
	localparam logic [7:0] SELECT_ADDR = 8'h04;     // counter select port
	localparam logic [7:0] DATA_ADDR = 8'h08;       // counter data port
	localparam logic [7:0] REF_MSB_ADDR = 8'h0C;    // reference and msb port
	localparam logic [7:0] ACTIVE_ADDR = 8'h10;     // active divisor, read only
	localparam logic [7:0] STATUS_ADDR = 8'h14;     // loop status, read only

	// ===========================================
	// field positions
	localparam int SWALLOW_BAND_POS = 0;            // mode register
	localparam int UPPER_BAND_POS = 1;
	localparam int OFFSET_MINUS_POS = 2;
	localparam int OFFSET_PLUS_POS = 3;
	localparam int MSB_POS = 3;                     // reference and msb register
	localparam int STATUS_OFF_POS = 0;              // status register
	localparam int STATUS_LOW_POS = 1;

	// ===========================================
	// widths
	localparam int NIBBLE_W = 4;
	localparam int GROUPS = 4;
	localparam int SEL_W = 2;
	localparam int REF_W = 3;
	localparam int DIV_W = 17;
	localparam int SWALLOW_W = 4;
	localparam int MAIN_W = 13;

	// ===========================================
	// reset values and codes
	localparam logic [3:0] MODE_RESET = 4'h0;
	localparam logic [REF_W-1:0] REF_OFF = 3'h7;    // all ones turns the loop off
	localparam logic [SEL_W-1:0] SEL_RESET = 2'h0;
	localparam logic [DIV_W-1:0] DIV_RESET = 17'h00010;

	// ===========================================
	// prescaler moduli
	localparam logic [SWALLOW_W-1:0] LONG_LAST = 4'hF;   // divide by 16
	localparam logic [SWALLOW_W-1:0] SHORT_LAST = 4'hE;  // divide by 15
	localparam logic [DIV_W-1:0] SHORT_MOD = 17'h0000F;

	typedef enum logic [1:0] {
		direct_divide_mode,
		swallow_low_mode,
		swallow_high_mode,
		doubled_swallow_mode
	} band_mode_t;
endpackage

//--- rf_source_model.sv
`timescale 1ns/1ps
`default_nettype none
// ===========================================
// oscillator model on the far side of the band inputs
module rf_source_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	input wire logic low_band_pulldown,
	input wire logic high_band_pulldown,
	output logic low_band_rf_input,
	output logic high_band_rf_input
);
	logic [1:0] phase; // free running phase
	logic wave; // square wave, low at least one cycle between highs
	// phase advances every cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
		end
	end
	// slow halves the rate so both input edge rates get exercised
	assign wave = slow ? phase[1] : phase[0];
	// a pulled-down line reads low, never the last value
	assign low_band_rf_input = low_band_pulldown ? 1'b0 : wave;
	assign high_band_rf_input = high_band_pulldown ? 1'b0 : wave;
endmodule
`default_nettype wire

//--- pll_divider_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ===========================================
// bus and divider checks
module pll_divider_asserts
	import pll_divider_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic low_band_rf_input,
	input wire logic high_band_rf_input,
	input wire logic low_band_pulldown,
	input wire logic high_band_pulldown,
	input wire logic divided_out,
	input wire logic loop_off
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr; // completed write
	assign wr = psel && penable && pready && pwrite;
	a_one_wait: assert property (psel && penable && !$past(penable) |=> pready)
		else $error("answer not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error without ready or with data");
	a_mode_ok: assert property (psel && penable && pready && paddr == MODE_ADDR |-> !pslverr)
		else $error("mode access refused");
	// the reference lands at the write edge and the off flag is registered one edge later
	a_off_write: assert property (wr && paddr == REF_MSB_ADDR && pwdata[2:0] == REF_OFF |-> ##2 loop_off)
		else $error("loop not off");
	a_on_write: assert property (wr && paddr == REF_MSB_ADDR && pwdata[2:0] != REF_OFF |-> ##2 !loop_off)
		else $error("loop not on");
	a_off_pulldown: assert property (loop_off && $past(loop_off) |-> low_band_pulldown && high_band_pulldown)
		else $error("input not pulled down while off");
	a_one_pulldown: assert property (!loop_off && !$past(loop_off) |-> low_band_pulldown != high_band_pulldown)
		else $error("wrong input pulled down");
	a_off_silent: assert property (loop_off && $past(loop_off) |-> !divided_out)
		else $error("output while off");
	a_pulse_short: assert property (divided_out |=> !divided_out)
		else $error("output pulse too long");
endmodule
bind pll_programmable_divider pll_divider_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .low_band_rf_input(low_band_rf_input), .high_band_rf_input(high_band_rf_input),
	.low_band_pulldown(low_band_pulldown), .high_band_pulldown(high_band_pulldown),
	.divided_out(divided_out), .loop_off(loop_off));
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
// ===========================================
// bench top
module tb
	import pll_divider_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, er;
	logic lo_in, hi_in, lo_pd, hi_pd, dout, off;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	int n_errors, n_tests, cyc, i, k;
	// mode bits and expected input edges per division
	localparam logic [3:0] MD [8] = '{4'h0, 4'h8, 4'h1, 4'h2, 4'h6, 4'hA, 4'h3, 4'h7};
	localparam int ED [8] = '{16, 16, 255, 255, 254, 256, 510, 508};
	pll_programmable_divider i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.low_band_rf_input(lo_in), .high_band_rf_input(hi_in), .low_band_pulldown(lo_pd),
		.high_band_pulldown(hi_pd), .divided_out(dout), .loop_off(off));
	rf_source_model i_src (.pclk(pclk), .presetn(presetn), .slow(slow), .low_band_pulldown(lo_pd),
		.high_band_pulldown(hi_pd), .low_band_rf_input(lo_in), .high_band_rf_input(hi_in));
	// ===========================================
	// clock and hang guard
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_errors = n_errors + 1;
			final_report();
		end
	end
	// ===========================================
	// tasks
	task automatic final_report();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			n_errors++;
		end
	endtask
	// one apb transfer; waits for ready however long it takes
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// select group zero, four nibbles, msb last
	task automatic load(input logic [16:0] n);
		int g;
		apb(1'b1, SELECT_ADDR, 32'h0, rd, er);
		for (g = 0; g < 4; g++) apb(1'b1, DATA_ADDR, {28'h0, n[4*g+:4]}, rd, er);
		apb(1'b1, REF_MSB_ADDR, {28'h0, n[16], 3'h0}, rd, er);
	endtask
	// cycles until the next output pulse, bounded
	task automatic pulse(output int c);
		c = 0;
		do begin
			@(posedge pclk);
			c++;
		end while (dout !== 1'b1 && c < 5000);
	endtask
	// ===========================================
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, slow, paddr, pwdata} = '0;
		{n_errors, n_tests, cyc} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, STATUS_ADDR, 32'h0, rd, er);
		chk(rd, 32'h3);
		apb(1'b0, ACTIVE_ADDR, 32'h0, rd, er);
		chk(rd, {15'h0, DIV_RESET});
		apb(1'b0, 8'h18, 32'h0, rd, er);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		$display("test reset done");
		load(17'h1FFFF);
		apb(1'b0, REF_MSB_ADDR, 32'h0, rd, er);
		chk(rd, 32'h8);
		apb(1'b1, SELECT_ADDR, 32'h2, rd, er);
		apb(1'b0, DATA_ADDR, 32'h0, rd, er);
		chk(rd, 32'hF);
		apb(1'b1, DATA_ADDR, 32'h5, rd, er);
		apb(1'b0, SELECT_ADDR, 32'h0, rd, er);
		chk(rd, 32'h0);
		apb(1'b0, ACTIVE_ADDR, 32'h0, rd, er);
		chk(rd, 32'h1FFFF);
		apb(1'b1, REF_MSB_ADDR, 32'h0, rd, er);
		apb(1'b0, ACTIVE_ADDR, 32'h0, rd, er);
		chk(rd, 32'h05FFF);
		$display("test select done");
		for (i = 0; i < 8; i++) begin
			slow <= (i >= 6);
			apb(1'b1, MODE_ADDR, {28'h0, MD[i]}, rd, er);
			apb(1'b0, MODE_ADDR, 32'h0, rd, er);
			chk(rd, {28'h0, MD[i]});
			load(i < 2 ? 17'h0010F : 17'h000FF);
			chk(lo_pd, MD[i][UPPER_BAND_POS]);
			chk(hi_pd, !MD[i][UPPER_BAND_POS]);
			pulse(k);
			pulse(k);
			chk(k, ED[i] * (i >= 6 ? 4 : 2));
			$display("test divide %0d done", i);
		end
		apb(1'b1, REF_MSB_ADDR, {29'h0, REF_OFF}, rd, er);
		// off flag and pulldowns are registered one edge after the reference lands
		repeat (2) @(posedge pclk);
		chk({off, hi_pd, lo_pd}, 3'h7);
		k = 0;
		repeat (200) begin
			@(posedge pclk);
			if (dout === 1'b1) k++;
		end
		chk(k, 0);
		$display("test off done");
		final_report();
	end
endmodule
`default_nettype wire
